// ---- logic/ch1_out_consts.vh ----
// Constants of the channel one output stage: register offsets, fields,
// reset values, codes and limits.
// Assumes quantities arrive as signed counts where 10000 counts is full scale.
`ifndef CH1_OUT_CONSTS_VH
`define CH1_OUT_CONSTS_VH

// ----------------------------------------------------------------------
// Register offsets (byte addresses, one word each)
// ----------------------------------------------------------------------
`define REG_CTRL        8'h00
`define REG_EXPAND      8'h04
`define REG_OFFSET_X    8'h08
`define REG_OFFSET_RV   8'h0c
`define REG_OFFSET_RDBM 8'h10
`define REG_STATUS      8'h14
`define REG_DISP_VAL    8'h18
`define REG_OUT_VAL     8'h1c

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define CTRL_QSEL_LSB   0
`define CTRL_QSEL_MSB   2
`define CTRL_SRC_BIT    3
`define CTRL_RATIO_LSB  4
`define CTRL_RATIO_MSB  5
`define CTRL_OFSEN_LSB  6
`define CTRL_OFSEN_MSB  8
`define CTRL_WIDTH      9
`define CTRL_RESET      9'h000
`define EXPAND_WIDTH    10
`define EXPAND_RESET    10'h000
`define OFFSET_RESET    16'h0000

// ----------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------
`define STAT_UNDERFLOW  0
`define STAT_OUT_OVERLOAD_FLAG   1
`define STAT_DISP_OVERLOAD_FLAG  2
`define STAT_EXP_IND    3
`define STAT_DIG_LSB    4
`define STAT_DIG_MSB    5
`define STAT_BUSY       6

// ----------------------------------------------------------------------
// Codes
// ----------------------------------------------------------------------
`define Q_X             3'h0
`define Q_RV            3'h1
`define Q_RDBM          3'h2
`define Q_XNOISE        3'h3
`define Q_AUX1          3'h4
`define EXP_X1          2'h0
`define EXP_X10         2'h1
`define EXP_EXPAND_BY_HUNDRED        2'h2
`define RATIO_OFF       2'h0
`define RATIO_AUX1      2'h1
`define RATIO_AUX2      2'h2
`define SRC_DISPLAY     1'b0
`define SRC_X           1'b1

// ----------------------------------------------------------------------
// Limits (counts, 1 count = 0.01 % of full scale = 1 mV at the output)
// ----------------------------------------------------------------------
`define DISP_LIMIT_CNT  32'h00002af8
`define OUT_LIMIT_MV    32'h00002904
`define UNDERFLOW_MV    16'h0032
`define RATIO_NORM_MV   16'h03e8
`define DIV_STEPS       6'h20

`endif

// ---- logic/expand_stage.v ----
// Expand multiplier with a magnitude limit check and a saturated result.
// Assumes a signed input in counts; purely combinational, the caller registers.
`timescale 1ns/100ps
`include "ch1_out_consts.vh"

module expand_stage #(
    parameter [31:0] LIMIT = 32'h00000000
) (
    input  wire [23:0] value_i,
    input  wire [1:0]  factor_i,
    output reg  [15:0] scaled_o,
    output wire        over_o
);
    wire signed [31:0] val_s = {{8{value_i[23]}}, value_i};
    reg  signed [31:0] prod;
    wire        [31:0] mag   = prod[31] ? (~prod + 32'h00000001) : prod;

    // --------------------------------------------------------------
    // Multiply and compare
    // --------------------------------------------------------------
    always @* begin
        case (factor_i)
            `EXP_X10:  prod = val_s * 32'sh0000000a;
            `EXP_EXPAND_BY_HUNDRED: prod = val_s * 32'sh00000064;
            default:   prod = val_s;
        endcase
        if (prod > 32'sh00007fff) begin
            scaled_o = 16'h7fff;
        end else if (prod < -32'sh00007fff) begin
            scaled_o = 16'h8001;
        end else begin
            scaled_o = prod[15:0];
        end
    end

    // Limit is taken on the expanded value, so the range shrinks by the factor
    assign over_o = (mag > LIMIT);

endmodule // expand_stage

// ---- logic/channel_one_analog_out_stage.v ----
// Channel one output stage: offset, ratio, expand, source select, overload
// and ratio underflow detection, with a small register port.
// Assumes all inputs are synchronous to clk_i and sample_i pulses one cycle
// per new set of upstream quantities.
//
// Contract
// - Underflow flag on while selected ratio aux input magnitude is below 50 mV.
// - One expand factor per displayed quantity: times one, ten or hundred.
// - Light the ten or hundred indicator for the factor; none at one.
// - Analog output multiplied by the active factor before the converter.
// - Display value unchanged, one extra digit at ten, two at hundred.
// - In-display expand indicator on when shown value's factor is not one.
// - Expand acts only at output, after offset and ratio; internals untouched.
// - Output source selects display quantity or X for the analog output.
// - Display source: 10 V is display full scale with display settings.
// - X source: 10 V is full scale with X offset, ratio and expand.
// - No indication of the output expand when X drives another display.
// - One X offset, ratio and expand shared; other quantities keep their own.
// - Output overload flag when analog output exceeds 10.5 V magnitude.
// - Display overload beyond 110 percent full scale divided by the factor.
// - Ratio off, by aux one or aux two, divisor normalised to 1.000 V.
// - Offsets are a percentage of full scale sensitivity.
//
// Chosen here: the register addresses and the strobed register port.
`timescale 1ns/100ps
`include "ch1_out_consts.vh"

module channel_one_analog_out_stage (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire [7:0]  addr_i,
    input  wire [31:0] wdata_i,
    input  wire        we_i,
    input  wire        re_i,
    output reg  [31:0] rdata_o,
    input  wire        sample_i,
    input  wire [15:0] x_i,
    input  wire [15:0] rv_i,
    input  wire [15:0] rdbm_i,
    input  wire [15:0] xnoise_i,
    input  wire [15:0] aux1_mv_i,
    input  wire [15:0] aux2_mv_i,
    output reg  [15:0] channel_one_analog_out_o,
    output reg         out_valid_o,
    output reg  [23:0] disp_value_o,
    output reg  [1:0]  disp_extra_digits_o,
    output reg         expand_by_ten_o,
    output reg         expand_by_hundred_o,
    output reg         disp_expand_ind_o,
    output reg         overload_flag_out_o,
    output reg         overload_flag_disp_o,
    output reg         underflow_o,
    output wire        busy_o
);
    // --------------------------------------------------------------
    // Sequencer states
    // --------------------------------------------------------------
    localparam [1:0] S_IDLE = 2'h0;
    localparam [1:0] S_DISP = 2'h1;
    localparam [1:0] S_X    = 2'h2;
    localparam [1:0] S_DONE = 2'h3;

    // --------------------------------------------------------------
    // Software state
    // --------------------------------------------------------------
    reg  [`CTRL_WIDTH-1:0]   ctrl_q;
    reg  [`EXPAND_WIDTH-1:0] expand_q;
    reg  [15:0]              ofs_x_q;
    reg  [15:0]              ofs_rv_q;
    reg  [15:0]              ofs_rdbm_q;

    wire [2:0] qsel      = ctrl_q[`CTRL_QSEL_MSB:`CTRL_QSEL_LSB];
    wire       out_src   = ctrl_q[`CTRL_SRC_BIT];
    wire [1:0] ratio_sel = ctrl_q[`CTRL_RATIO_MSB:`CTRL_RATIO_LSB];
    wire [2:0] ofs_en    = ctrl_q[`CTRL_OFSEN_MSB:`CTRL_OFSEN_LSB];

    // --------------------------------------------------------------
    // Expand factor per quantity
    // --------------------------------------------------------------
    // Two bits per quantity code; dBm and aux never expand.
    function [1:0] eff_expand;
        input [2:0]                q;
        input [`EXPAND_WIDTH-1:0]  e;
        reg   [1:0]                f;
        begin
            f = 2'h0;
            case (q)
                `Q_X:      f = e[1:0];
                `Q_RV:     f = e[3:2];
                `Q_XNOISE: f = e[7:6];
                default:   f = `EXP_X1;
            endcase
            eff_expand = (f == 2'h3) ? `EXP_X1 : f;
        end
    endfunction

    wire [1:0] disp_exp = eff_expand(qsel, expand_q);
    wire [1:0] x_exp    = eff_expand(`Q_X, expand_q);
    wire [1:0] out_exp  = (out_src == `SRC_X) ? x_exp : disp_exp;

    // --------------------------------------------------------------
    // Offset before ratio
    // --------------------------------------------------------------
    // Offset counts are 0.01 % of full scale, so they add straight on.
    wire signed [23:0] x_s    = {{8{x_i[15]}}, x_i};
    wire signed [23:0] rv_s   = {{8{rv_i[15]}}, rv_i};
    wire signed [23:0] rdbm_s = {{8{rdbm_i[15]}}, rdbm_i};
    wire signed [23:0] xn_s   = {{8{xnoise_i[15]}}, xnoise_i};
    wire signed [23:0] aux1_s = {{8{aux1_mv_i[15]}}, aux1_mv_i};
    wire signed [23:0] ox_s   = {{8{ofs_x_q[15]}}, ofs_x_q};
    wire signed [23:0] orv_s  = {{8{ofs_rv_q[15]}}, ofs_rv_q};
    wire signed [23:0] odb_s  = {{8{ofs_rdbm_q[15]}}, ofs_rdbm_q};

    wire [23:0] x_ofs  = ofs_en[0] ? (x_s + ox_s) : x_s;
    wire [23:0] rv_ofs = ofs_en[1] ? (rv_s + orv_s) : rv_s;
    wire [23:0] db_ofs = ofs_en[2] ? (rdbm_s + odb_s) : rdbm_s;

    reg  [23:0] disp_pre;
    reg         disp_ratioed;
    always @* begin
        case (qsel)
            `Q_RV: begin
                disp_pre     = rv_ofs;
                disp_ratioed = 1'b1;
            end
            `Q_RDBM: begin
                disp_pre     = db_ofs;
                disp_ratioed = 1'b0;
            end
            `Q_XNOISE: begin
                disp_pre     = xn_s;
                disp_ratioed = 1'b1;
            end
            `Q_AUX1: begin
                disp_pre     = aux1_s;
                disp_ratioed = 1'b0;
            end
            default: begin
                disp_pre     = x_ofs;
                disp_ratioed = 1'b1;
            end
        endcase
    end

    // --------------------------------------------------------------
    // Ratio divisor and underflow
    // --------------------------------------------------------------
    wire [15:0] aux_sel  = (ratio_sel == `RATIO_AUX2) ? aux2_mv_i : aux1_mv_i;
    wire        ratio_on = (ratio_sel == `RATIO_AUX1) || (ratio_sel == `RATIO_AUX2);
    wire [15:0] aux_mag  = aux_sel[15] ? (~aux_sel + 16'h0001) : aux_sel;
    wire        under_now = ratio_on && (aux_mag < `UNDERFLOW_MV);

    // --------------------------------------------------------------
    // Sample sequencer and shared divider
    // --------------------------------------------------------------
    // One restoring divider serves both paths in turn; a sample that
    // arrives while busy is dropped, the previous result stays shown.
    reg  [1:0]  state_q;
    reg  [23:0] disp_pre_q;
    reg  [23:0] x_pre_q;
    reg         disp_div_q;
    reg         x_div_q;
    reg  [15:0] den_q;
    reg         den_neg_q;
    reg         under_q;
    reg  [31:0] num_q;
    reg  [16:0] rem_q;
    reg  [5:0]  cnt_q;
    reg         neg_q;
    reg  [23:0] disp_res_q;
    reg  [23:0] x_res_q;
    reg         div_run_q;

    assign busy_o = (state_q != S_IDLE);

    wire [23:0] cur_pre   = (state_q == S_DISP) ? disp_pre_q : x_pre_q;
    wire [23:0] cur_mag   = cur_pre[23] ? (~cur_pre + 24'h000001) : cur_pre;
    wire [31:0] num_start = {8'h00, cur_mag} * {16'h0000, `RATIO_NORM_MV};
    wire [16:0] rem_shift = {rem_q[15:0], num_q[31]};
    wire        q_bit     = (rem_shift >= {1'b0, den_q});
    wire [16:0] rem_next  = q_bit ? (rem_shift - {1'b0, den_q}) : rem_shift;
    wire [31:0] quot_next = {num_q[30:0], q_bit};

    // Saturate the quotient into the signed 24-bit range
    wire [23:0] quot_sat  = (quot_next > 32'h007fffff) ? 24'h7fffff : quot_next[23:0];
    wire [23:0] quot_res  = neg_q ? (~quot_sat + 24'h000001) : quot_sat;
    wire        div_last  = div_run_q && (cnt_q == `DIV_STEPS - 6'h01);

    always @(posedge clk_i) begin
        if (rst_i) begin
            state_q    <= S_IDLE;
            disp_pre_q <= 24'h000000;
            x_pre_q    <= 24'h000000;
            disp_div_q <= 1'b0;
            x_div_q    <= 1'b0;
            den_q      <= 16'h0000;
            den_neg_q  <= 1'b0;
            under_q    <= 1'b0;
            num_q      <= 32'h00000000;
            rem_q      <= 17'h00000;
            cnt_q      <= 6'h00;
            neg_q      <= 1'b0;
            div_run_q  <= 1'b0;
            disp_res_q <= 24'h000000;
            x_res_q    <= 24'h000000;
        end else begin
            case (state_q)
                S_IDLE: begin
                    if (sample_i) begin
                        disp_pre_q <= disp_pre;
                        x_pre_q    <= x_ofs;
                        disp_div_q <= ratio_on && disp_ratioed;
                        x_div_q    <= ratio_on;
                        den_q      <= aux_mag;
                        den_neg_q  <= aux_sel[15];
                        under_q    <= under_now;
                        div_run_q  <= 1'b0;
                        state_q    <= S_DISP;
                    end
                end
                S_DISP, S_X: begin
                    if (!((state_q == S_DISP) ? disp_div_q : x_div_q)) begin
                        // Ratio off, or a display quantity that is not ratioed (dBm, aux): the value passes unchanged
                        if (state_q == S_DISP) begin
                            disp_res_q <= disp_pre_q;
                            state_q    <= S_X;
                        end else begin
                            x_res_q <= x_pre_q;
                            state_q <= S_DONE;
                        end
                    end else if (!div_run_q) begin
                        num_q     <= num_start;
                        rem_q     <= 17'h00000;
                        cnt_q     <= 6'h00;
                        neg_q     <= cur_pre[23] ^ den_neg_q;
                        div_run_q <= 1'b1;
                    end else begin
                        num_q <= quot_next;
                        rem_q <= rem_next;
                        cnt_q <= cnt_q + 6'h01;
                        if (div_last) begin
                            div_run_q <= 1'b0;
                            if (state_q == S_DISP) begin
                                disp_res_q <= quot_res;
                                state_q    <= S_X;
                            end else begin
                                x_res_q <= quot_res;
                                state_q <= S_DONE;
                            end
                        end
                    end
                end
                S_DONE: begin
                    state_q <= S_IDLE;
                end
                default: begin
                    state_q <= S_IDLE;
                end
            endcase
        end
    end

    // --------------------------------------------------------------
    // Expand stages
    // --------------------------------------------------------------
    // Expansion only touches what leaves the block; the ratioed values
    // above are never scaled.
    wire [23:0] out_pre = (out_src == `SRC_X) ? x_res_q : disp_res_q;
    wire [15:0] out_scaled;
    wire        out_over;
    wire        disp_over;

    expand_stage #(
        .LIMIT (`OUT_LIMIT_MV)
    ) u_out_stage (
        .value_i  (out_pre),
        .factor_i (out_exp),
        .scaled_o (out_scaled),
        .over_o   (out_over)
    );

    expand_stage #(
        .LIMIT (`DISP_LIMIT_CNT)
    ) u_disp_stage (
        .value_i  (disp_res_q),
        .factor_i (disp_exp),
        .scaled_o (),
        .over_o   (disp_over)
    );

    // --------------------------------------------------------------
    // Output update: values once per processed sample, indicators every cycle
    // --------------------------------------------------------------
    always @(posedge clk_i) begin
        if (rst_i) begin
            channel_one_analog_out_o <= 16'h0000;
            out_valid_o              <= 1'b0;
            disp_value_o             <= 24'h000000;
            disp_extra_digits_o      <= 2'h0;
            expand_by_ten_o          <= 1'b0;
            expand_by_hundred_o      <= 1'b0;
            disp_expand_ind_o        <= 1'b0;
            overload_flag_out_o      <= 1'b0;
            overload_flag_disp_o     <= 1'b0;
            underflow_o              <= 1'b0;
        end else begin
            out_valid_o <= (state_q == S_DONE);
            if (state_q == S_DONE) begin
                // 1 count is 1 mV, so full scale lands on 10 V
                channel_one_analog_out_o <= out_scaled;
                disp_value_o             <= disp_res_q;
                overload_flag_out_o      <= out_over;
                overload_flag_disp_o     <= disp_over;
                underflow_o              <= under_q;
            end
            // Indicators follow the display quantity only, never the X output
            expand_by_ten_o     <= (disp_exp == `EXP_X10);
            expand_by_hundred_o <= (disp_exp == `EXP_EXPAND_BY_HUNDRED);
            disp_expand_ind_o   <= (disp_exp != `EXP_X1);
            disp_extra_digits_o <= (disp_exp == `EXP_EXPAND_BY_HUNDRED) ? 2'h2 :
                                   (disp_exp == `EXP_X10)  ? 2'h1 : 2'h0;
        end
    end

    // --------------------------------------------------------------
    // Register port
    // --------------------------------------------------------------
    always @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q     <= `CTRL_RESET;
            expand_q   <= `EXPAND_RESET;
            ofs_x_q    <= `OFFSET_RESET;
            ofs_rv_q   <= `OFFSET_RESET;
            ofs_rdbm_q <= `OFFSET_RESET;
        end else if (we_i) begin
            case (addr_i)
                `REG_CTRL:        ctrl_q     <= wdata_i[`CTRL_WIDTH-1:0];
                `REG_EXPAND:      expand_q   <= wdata_i[`EXPAND_WIDTH-1:0];
                `REG_OFFSET_X:    ofs_x_q    <= wdata_i[15:0];
                `REG_OFFSET_RV:   ofs_rv_q   <= wdata_i[15:0];
                `REG_OFFSET_RDBM: ofs_rdbm_q <= wdata_i[15:0];
                default:          ctrl_q     <= ctrl_q;
            endcase
        end
    end

    reg [31:0] rd_mux;
    always @* begin
        rd_mux = 32'h00000000;
        case (addr_i)
            `REG_CTRL:        rd_mux[`CTRL_WIDTH-1:0]   = ctrl_q;
            `REG_EXPAND:      rd_mux[`EXPAND_WIDTH-1:0] = expand_q;
            `REG_OFFSET_X:    rd_mux[15:0]              = ofs_x_q;
            `REG_OFFSET_RV:   rd_mux[15:0]              = ofs_rv_q;
            `REG_OFFSET_RDBM: rd_mux[15:0]              = ofs_rdbm_q;
            `REG_STATUS: begin
                rd_mux[`STAT_UNDERFLOW] = underflow_o;
                rd_mux[`STAT_OUT_OVERLOAD_FLAG]  = overload_flag_out_o;
                rd_mux[`STAT_DISP_OVERLOAD_FLAG] = overload_flag_disp_o;
                rd_mux[`STAT_EXP_IND]   = disp_expand_ind_o;
                rd_mux[`STAT_DIG_MSB:`STAT_DIG_LSB] = disp_extra_digits_o;
                rd_mux[`STAT_BUSY]      = busy_o;
            end
            `REG_DISP_VAL:    rd_mux = {{8{disp_value_o[23]}}, disp_value_o};
            `REG_OUT_VAL:     rd_mux = {{16{channel_one_analog_out_o[15]}},
                                        channel_one_analog_out_o};
            default:          rd_mux = 32'h00000000;
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always @(posedge clk_i) begin
        if (rst_i) begin
            rdata_o <= 32'h00000000;
        end else begin
            rdata_o <= re_i ? rd_mux : 32'h00000000;
        end
    end

endmodule // channel_one_analog_out_stage

// ---- test/channel_one_analog_out_checker.sv ----
// Port assertions for the channel one output stage.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps
module channel_one_analog_out_checker (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        sample_i,
    input wire logic        busy_o,
    input wire logic        out_valid_o,
    input wire logic [15:0] channel_one_analog_out_o,
    input wire logic [23:0] disp_value_o,
    input wire logic [1:0]  disp_extra_digits_o,
    input wire logic        expand_by_ten_o,
    input wire logic        expand_by_hundred_o,
    input wire logic        disp_expand_ind_o,
    input wire logic        overload_flag_out_o,
    input wire logic        overload_flag_disp_o
);
    // ----------------
    // Magnitudes
    // ----------------
    // Factor read from the indicators, so the bench must not change expand mid-sample
    wire logic [15:0] amag = channel_one_analog_out_o[15] ? -channel_one_analog_out_o
                                                          : channel_one_analog_out_o;
    wire logic [23:0] dmag = disp_value_o[23] ? -disp_value_o : disp_value_o;
    wire logic [31:0] dprod = {8'h00, dmag} * (expand_by_hundred_o ? 32'h64 :
                                               expand_by_ten_o ? 32'h0a : 32'h01);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    chk_ind_onehot: assert property (!(expand_by_ten_o && expand_by_hundred_o))
        else $error("both expand indicators lit");
    chk_digit_count: assert property (
        disp_extra_digits_o == {expand_by_hundred_o, expand_by_ten_o})
        else $error("extra digits disagree with factor");
    chk_disp_indicator: assert property (
        disp_expand_ind_o == (expand_by_ten_o | expand_by_hundred_o))
        else $error("display expand indicator wrong");
    chk_valid_pulse: assert property (out_valid_o |=> !out_valid_o)
        else $error("result strobe longer than one cycle");
    chk_result_bound: assert property (sample_i && !busy_o |-> ##[4:70] out_valid_o)
        else $error("no result after accepted sample");
    chk_busy_span: assert property (sample_i && !busy_o |=> busy_o [*3])
        else $error("busy not held after sample");
    chk_out_overload: assert property (out_valid_o && amag > 16'h2904 |-> overload_flag_out_o)
        else $error("output overload missed");
    chk_disp_overload: assert property (
        out_valid_o |-> overload_flag_disp_o == (dprod > 32'h00002af8))
        else $error("display overload wrong");
    chk_flags_hold: assert property (
        !out_valid_o |-> $stable({overload_flag_out_o, overload_flag_disp_o}))
        else $error("flags moved without a result");
endmodule // channel_one_analog_out_checker

bind channel_one_analog_out_stage channel_one_analog_out_checker channel_one_analog_out_checker_inst (.clk_i, .rst_i, .sample_i,
    .busy_o, .out_valid_o, .channel_one_analog_out_o, .disp_value_o, .disp_extra_digits_o,
    .expand_by_ten_o, .expand_by_hundred_o, .disp_expand_ind_o, .overload_flag_out_o,
    .overload_flag_disp_o);

// ---- test/channel_one_analog_out_stage_tb.sv ----
// Self-checking bench for the channel one output stage.
// Assumes the register map and codes of ch1_out_consts.vh.
`timescale 1ns/100ps
`include "ch1_out_consts.vh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin num_errors++; \
    $display("mismatch t=%0t got %h exp %h", $time, (a), (b)); end end
module channel_one_analog_out_stage_tb;
    logic        clk_i = 1'b0, rst_i = 1'b1, we_i = 1'b0, re_i = 1'b0, sample_i = 1'b0;
    logic [7:0]  addr_i = 8'h00;
    logic [31:0] wdata_i = 32'h0, rdata_o, d;
    logic [15:0] x_i = 16'h0, rv_i = 16'h0, xnoise_i = 16'h0, rdbm_i = 16'h0;
    logic [15:0] aux1_mv_i = 16'h03e8, aux2_mv_i = 16'h03e8, channel_one_analog_out_o;
    logic [23:0] disp_value_o;
    logic [1:0]  disp_extra_digits_o;
    logic        out_valid_o, expand_by_ten_o, expand_by_hundred_o, disp_expand_ind_o;
    logic        overload_flag_out_o, overload_flag_disp_o, underflow_o, busy_o;
    int          num_errors = 0, tests_run = 0;
    channel_one_analog_out_stage channel_one_analog_out_stage_inst (.clk_i, .rst_i, .addr_i, .wdata_i, .we_i, .re_i,
        .rdata_o, .sample_i, .x_i, .rv_i, .rdbm_i, .xnoise_i, .aux1_mv_i, .aux2_mv_i,
        .channel_one_analog_out_o, .out_valid_o, .disp_value_o, .disp_extra_digits_o,
        .expand_by_ten_o, .expand_by_hundred_o, .disp_expand_ind_o, .overload_flag_out_o,
        .overload_flag_disp_o, .underflow_o, .busy_o);
    always #12.5 clk_i = ~clk_i;
    // ----------------
    // Bus and sample helpers
    // ----------------
    task tick(input int n); repeat (n) @(posedge clk_i); endtask
    // Idle edge after each write keeps two writes from touching the strobe in one step
    task wr(input [7:0] a, input [31:0] v);
        addr_i <= a; wdata_i <= v; we_i <= 1'b1; @(posedge clk_i);
        we_i <= 1'b0; @(posedge clk_i);
    endtask
    task rd(input [7:0] a);
        addr_i <= a; re_i <= 1'b1; @(posedge clk_i);
        re_i <= 1'b0; @(posedge clk_i); d = rdata_o;
    endtask
    task smp(input [15:0] x, input [15:0] a1, input [15:0] a2);
        int n;
        x_i <= x; rv_i <= 16'h01f4; aux1_mv_i <= a1; aux2_mv_i <= a2;
        sample_i <= 1'b1; @(posedge clk_i); sample_i <= 1'b0; n = 0;
        while (out_valid_o !== 1'b1) begin
            if (n == 100) begin num_errors++; final_report; end
            @(posedge clk_i); n++;
        end
    endtask
    task xo(input [1:0] e, input [15:0] x, input [15:0] ao, input vo, input vd);
        wr(`REG_EXPAND, {30'h0, e}); smp(x, 16'h03e8, 16'h03e8);
        `CHK(channel_one_analog_out_o, ao);
        `CHK(disp_value_o, {{8{x[15]}}, x});
        `CHK(overload_flag_out_o, vo);
        `CHK(overload_flag_disp_o, vd);
    endtask
    task uf(input [8:0] c, input [15:0] a1, input [15:0] a2, input e);
        wr(`REG_CTRL, {23'h0, c}); smp(16'h03e8, a1, a2);
        `CHK(underflow_o, e);
    endtask
    // ----------------
    // Scenarios
    // ----------------
    task test_reset;
        rd(`REG_EXPAND); `CHK(d, 32'h0);
        rd(`REG_STATUS); `CHK(d, 32'h0);
        rd(8'h20); `CHK(d, 32'h0);
        $display("test_reset done");
    endtask
    task test_indicators;
        logic [1:0] c;
        for (int i = 0; i < 4; i++) begin
            c = i[1:0]; wr(`REG_EXPAND, {30'h0, c}); tick(2);
            `CHK(expand_by_ten_o, c == `EXP_X10);
            `CHK(expand_by_hundred_o, c == `EXP_EXPAND_BY_HUNDRED);
            `CHK(disp_expand_ind_o, c == `EXP_X10 || c == `EXP_EXPAND_BY_HUNDRED);
            `CHK(disp_extra_digits_o, (c == 2'h3) ? 2'h0 : c);
        end
        $display("test_indicators done");
    endtask
    task test_expand_out;
        xo(`EXP_X1, 16'h2904, 16'h2904, 1'b0, 1'b0);
        xo(`EXP_X1, 16'h2905, 16'h2905, 1'b1, 1'b0);
        xo(`EXP_X1, 16'h2af9, 16'h2af9, 1'b1, 1'b1);
        xo(`EXP_X10, 16'h041a, 16'h2904, 1'b0, 1'b0);
        xo(`EXP_X10, 16'h04d2, 16'h3034, 1'b1, 1'b1);
        xo(`EXP_EXPAND_BY_HUNDRED, 16'h04d2, 16'h7fff, 1'b1, 1'b1);
        rd(`REG_STATUS); `CHK(d, 32'h0000002e);
        rd(`REG_OUT_VAL); `CHK(d, 32'h00007fff);
        xo(`EXP_EXPAND_BY_HUNDRED, 16'hff92, 16'hd508, 1'b1, 1'b0);
        xo(2'h3, 16'h04d2, 16'h04d2, 1'b0, 1'b0);
        $display("test_expand_out done");
    endtask
    task test_source;
        wr(`REG_CTRL, 32'h009); wr(`REG_EXPAND, 32'h001); smp(16'h0064, 16'h03e8, 16'h03e8);
        `CHK(channel_one_analog_out_o, 16'h03e8);
        `CHK(disp_value_o, 24'h0001f4);
        `CHK({expand_by_ten_o, disp_expand_ind_o}, 2'h0);
        wr(`REG_CTRL, 32'h001); smp(16'h0064, 16'h03e8, 16'h03e8);
        `CHK(channel_one_analog_out_o, 16'h01f4);
        // Xnoise keeps its own factor while X stays at ten
        xnoise_i <= 16'h0064; wr(`REG_CTRL, 32'h003); wr(`REG_EXPAND, 32'h081);
        smp(16'h0064, 16'h03e8, 16'h03e8);
        `CHK({channel_one_analog_out_o, expand_by_hundred_o}, 17'h04e21);
        $display("test_source done");
    endtask
    task test_ratio;
        uf(9'h010, 16'h01f4, 16'h03e8, 1'b0);
        `CHK(disp_value_o, 24'h0007d0);
        uf(9'h010, 16'h0031, 16'h03e8, 1'b1);
        uf(9'h010, 16'h0032, 16'h03e8, 1'b0);
        uf(9'h020, 16'h03e8, 16'hffcf, 1'b1);
        uf(9'h000, 16'h0000, 16'h0000, 1'b0);
        $display("test_ratio done");
    endtask
    task test_offset;
        wr(`REG_CTRL, 32'h040); wr(`REG_OFFSET_X, 32'h0000fc18);
        wr(`REG_EXPAND, 32'h001); smp(16'h04d2, 16'h03e8, 16'h03e8);
        `CHK(channel_one_analog_out_o, 16'h0924);
        `CHK(disp_value_o, 24'h0000ea);
        `CHK(overload_flag_out_o, 1'b0);
        `CHK(overload_flag_disp_o, 1'b0);
        $display("test_offset done");
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        tick(6);
        rst_i <= 1'b0;
        test_reset;
        test_indicators;
        test_expand_out;
        test_source;
        test_ratio;
        test_offset;
        final_report;
    end
endmodule // channel_one_analog_out_stage_tb
